// File: gp_register_and_io_map_tb.sv
/*
  gp_register_and_io_map_tb: self-checking bench of the data-memory mapper.
  assumes a registered wishbone ack and a core answer one cycle after acc_req_i.
*/
`timescale 1ns/1ps
module gp_register_and_io_map_tb
  import gprm_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic acc_req_i, acc_we_i, acc_alt_i, acc_pair_en_i, acc_done_o, acc_err_o;
  logic [2:0] acc_mode_i;
  logic [1:0] acc_width_i, acc_bit_i, acc_pair_i, io_width_o, mem_width_o, act_bank_o;
  logic [11:0] acc_addr_i, mem_addr_o;
  logic [7:0] acc_wdata_i, acc_rdata_o, io_wdata_o, io_rdata_i, mem_wdata_o, mem_rdata_i, d;
  logic io_sel_o, io_we_o, mem_sel_o, mem_we_o;
  logic [6:0] io_ofs_o;
  logic [22:0] tbl [12];
  int mismatches, samples_checked, cycles;

  gprm_map DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_req_i(acc_req_i), .acc_we_i(acc_we_i),
    .acc_mode_i(acc_mode_i), .acc_width_i(acc_width_i), .acc_addr_i(acc_addr_i),
    .acc_bit_i(acc_bit_i), .acc_alt_i(acc_alt_i), .acc_pair_i(acc_pair_i),
    .acc_pair_en_i(acc_pair_en_i), .acc_wdata_i(acc_wdata_i), .acc_rdata_o(acc_rdata_o),
    .acc_done_o(acc_done_o), .acc_err_o(acc_err_o), .io_sel_o(io_sel_o), .io_we_o(io_we_o),
    .io_ofs_o(io_ofs_o), .io_wdata_o(io_wdata_o), .io_width_o(io_width_o),
    .io_rdata_i(io_rdata_i), .mem_sel_o(mem_sel_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_width_o(mem_width_o),
    .mem_rdata_i(mem_rdata_i), .act_bank_o(act_bank_o));

  gprm_far_model FAR (.acc_req_i(acc_req_i), .acc_addr_i(acc_addr_i),
    .io_rdata_o(io_rdata_i), .mem_rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    // ack is sampled at each rising edge; read data is taken at that same edge
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      end_of_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic ctrl(input logic memory_bank_enable, input logic [3:0] memory_bank_select, input logic register_bank_enable,
                      input logic [1:0] register_bank_select);
    logic [31:0] w;
    w = 32'h0;
    w[CTRL_MBE_POS] = memory_bank_enable;
    w[CTRL_RBE_POS] = register_bank_enable;
    w[CTRL_RBS_POS +: 2] = register_bank_select;
    w[CTRL_MBS_POS +: 4] = memory_bank_select;
    wb(1'b1, REG_CTRL, w);
  endtask

  // outputs of the access stand for the cycle in which the task returns
  task automatic acc(input logic [2:0] m, input logic [1:0] w, input logic we,
                     input logic [11:0] a, input logic [7:0] wd, input logic [1:0] b,
                     input logic alt, input logic pen, input logic [1:0] pr);
    @(posedge clk_i);
    acc_req_i     <= 1'b1;
    acc_mode_i    <= m;
    acc_width_i   <= w;
    acc_we_i      <= we;
    acc_addr_i    <= a;
    acc_wdata_i   <= wd;
    acc_bit_i     <= b;
    acc_alt_i     <= alt;
    acc_pair_en_i <= pen;
    acc_pair_i    <= pr;
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    #1;
  endtask

  task automatic route(input logic io, input logic mem, input logic err);
    chk({acc_done_o, io_sel_o, mem_sel_o, acc_err_o}, {1'b1, io, mem, err});
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {acc_req_i, acc_we_i, acc_mode_i, acc_width_i, acc_addr_i, acc_bit_i} = '0;
    {acc_alt_i, acc_pair_i, acc_pair_en_i, acc_wdata_i} = '0;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, CTRL_RST);
    chk(act_bank_o, 2'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    ctrl(1'b0, 4'h0, 1'b1, 2'h2);
    // the bank output follows the settings one cycle later
    @(posedge clk_i);
    chk(act_bank_o, 2'h2);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0000_0022);
    ctrl(1'b0, 4'h0, 1'b0, 2'h3);
    @(posedge clk_i);
    chk(act_bank_o, 2'h0);
    // every pair of every bank, written by pair and read back by plain address
    for (int bk = 0; bk < 4; bk++) begin
      ctrl(1'b0, 4'h0, 1'b1, 2'(bk));
      for (int pr = 0; pr < 4; pr++) begin
        d = {2'(bk), 2'(pr), 4'hC};
        acc(GPRM_M_DIR, GPRM_W_8, 1'b1, 12'h0, d, 2'h0, 1'b0, 1'b1, 2'(pr));
        acc(GPRM_M_DIR, GPRM_W_8, 1'b0, 12'(8 * bk + 2 * pr), 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
        chk(acc_rdata_o, d);
      end
    end
    ctrl(1'b0, 4'h0, 1'b1, 2'h2);
    acc(GPRM_M_DIR, GPRM_W_8, 1'b1, 12'h0, 8'h3C, 2'h0, 1'b1, 1'b1, 2'h0);
    acc(GPRM_M_DIR, GPRM_W_8, 1'b0, 12'h018, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    chk(acc_rdata_o, 8'h3C);
    acc(GPRM_M_DIR, GPRM_W_4, 1'b1, 12'h005, 8'h09, 2'h0, 1'b0, 1'b0, 2'h0);
    acc(GPRM_M_DIR, GPRM_W_8, 1'b0, 12'h004, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    chk(acc_rdata_o, 8'h9C);
    // mode, width, bank enable, bank select, address, expect window
    tbl = '{{3'h0, 2'h0, 1'b0, 4'h3, 12'hFB0, 1'b1}, {3'h0, 2'h0, 1'b1, 4'hF, 12'hFB0, 1'b1},
            {3'h0, 2'h0, 1'b1, 4'h3, 12'hFB0, 1'b0}, {3'h1, 2'h0, 1'b1, 4'h3, 12'hFB0, 1'b1},
            {3'h2, 2'h0, 1'b1, 4'h3, 12'hFB0, 1'b1}, {3'h3, 2'h1, 1'b0, 4'h3, 12'hFB0, 1'b1},
            {3'h3, 2'h1, 1'b1, 4'hF, 12'hFB0, 1'b1}, {3'h3, 2'h1, 1'b1, 4'h3, 12'hFB0, 1'b0},
            {3'h4, 2'h1, 1'b1, 4'hF, 12'hFB0, 1'b1}, {3'h4, 2'h1, 1'b0, 4'h0, 12'hFB0, 1'b0},
            {3'h4, 2'h1, 1'b1, 4'h3, 12'hFB0, 1'b0}, {3'h3, 2'h1, 1'b0, 4'h0, 12'hF7F, 1'b0}};
    foreach (tbl[i]) begin
      ctrl(tbl[i][17], tbl[i][16:13], 1'b0, 2'h0);
      acc(tbl[i][22:20], tbl[i][19:18], 1'b0, tbl[i][12:1], 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
      route(tbl[i][0], ~tbl[i][0], 1'b0);
    end
    ctrl(1'b0, 4'h0, 1'b0, 2'h0);
    acc(GPRM_M_DIR, GPRM_W_8, 1'b0, 12'hF86, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b1, 1'b0, 1'b0);
    chk(acc_rdata_o, {4'h6, 4'h8} ^ 8'hA5);
    acc(GPRM_M_DIR, GPRM_W_8, 1'b0, 12'hF87, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b0, 1'b0, 1'b1);
    chk(acc_rdata_o, 8'h00);
    acc(GPRM_M_DIR, GPRM_W_8, 1'b1, 12'hF86, 8'h5A, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b0, 1'b0, 1'b1);
    acc(GPRM_M_DIR, GPRM_W_4, 1'b0, 12'hF86, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b0, 1'b0, 1'b1);
    acc(GPRM_M_IND, GPRM_W_8, 1'b0, 12'hF86, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b0, 1'b1, 1'b0);
    ctrl(1'b1, 4'hF, 1'b0, 2'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0000_0F01);
    acc(GPRM_M_IND, GPRM_W_8, 1'b0, 12'hF86, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b1, 1'b0, 1'b0);
    acc(GPRM_M_IND, GPRM_W_8, 1'b0, 12'hF87, 8'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b0, 1'b0, 1'b1);
    acc(GPRM_M_BIT_MEM, GPRM_W_1, 1'b1, 12'hF85, 8'h1, 2'h0, 1'b0, 1'b0, 2'h0);
    route(1'b0, 1'b0, 1'b1);
    acc(GPRM_M_BIT_MEM, GPRM_W_1, 1'b1, 12'hF85, 8'h1, 2'h3, 1'b0, 1'b0, 2'h0);
    route(1'b1, 1'b0, 1'b0);
    chk(io_we_o, 1'b1);
    wb(1'b0, REG_STAT, 32'h0);
    chk(q[4:0], 5'b10000);
    // five refusals so far: two odd bytes, a write to read-only, a bad width, a bad bit
    wb(1'b0, REG_VIOL, 32'h0);
    chk(q[7:0], 8'h05);
    wb(1'b1, REG_VIOL, 32'h0);
    wb(1'b0, REG_VIOL, 32'h0);
    chk(q[7:0], 8'h00);
    end_of_test();
  end
endmodule

// File: gprm_attr.sv
/*
  gprm_attr: access attribute table for the peripheral window F80H..FFFH.
  assumes the table is a constant; unlisted nibbles carry no access at all.
*/
`timescale 1ns/1ps
module gprm_attr
  import gprm_pkg::*;
(
  input  wire logic [6:0]        ofs_i,   // nibble offset within window
  output logic      [ATTR_W-1:0] attr_o   // access attribute bits
);
  // partial nibbles only allow bit 3; unlisted nibbles default to nothing
  always_comb begin
    case (ofs_i)
      7'h00, 7'h01: attr_o = 6'b010011; // stack pointer, byte r/w
      7'h02, 7'h03: attr_o = 6'b011001; // bank selects, read
      7'h04:        attr_o = 6'b001011; // stack bank select
      7'h05:        attr_o = 6'b101010; // timer mode, bit 3 only
      7'h06, 7'h07: attr_o = 6'b010001; // interval timer count
      7'h10:        attr_o = 6'b110010; // pulse gen mode, bit 3 only
      7'h11:        attr_o = 6'b010010;
      7'h14, 7'h15,
      7'h16, 7'h17: attr_o = 6'b010011; // modulo registers
      7'h18, 7'h19: attr_o = 6'b010010; // clock mode
      7'h20:        attr_o = 6'b110010; // counter 0 mode, bit 3 only
      7'h21:        attr_o = 6'b010010;
      7'h22:        attr_o = 6'b000110; // output enable flag
      7'h24, 7'h25: attr_o = 6'b010001; // counter 0 count
      7'h30:        attr_o = 6'b011111; // status/bank enable flags
      7'h31:        attr_o = 6'b010001;
      7'h32, 7'h33,
      7'h34, 7'h35,
      7'h36:        attr_o = 6'b001010;
      7'h37:        attr_o = 6'b000110;
      default:      attr_o = 6'b000000;
    endcase
  end
endmodule

// File: gprm_far_model.sv
/*
  gprm_far_model: peripheral hardware and ordinary data memory seen from the mapper.
  assumes read data is sampled by the mapper in the request cycle.
*/
`timescale 1ns/1ps
module gprm_far_model
  import gprm_pkg::*;
(
  input  wire logic        acc_req_i,   // core request pulse
  input  wire logic [11:0] acc_addr_i,  // addressed nibble
  output logic      [7:0]  io_rdata_o,  // peripheral read data
  output logic      [7:0]  mem_rdata_o  // data memory read data
);
  logic [7:0] pat;
  assign pat = {acc_addr_i[3:0], acc_addr_i[7:4]} ^ 8'hA5;
  // outside a request the lines show the inverse, so a stale sample cannot match
  assign io_rdata_o  = acc_req_i ? pat : ~pat;
  assign mem_rdata_o = acc_req_i ? ~pat : pat;
endmodule

// File: gprm_map.sv
/*
  gprm_map: data-memory mapping of the general registers and the
  peripheral window, with a wishbone slave for bank settings and status.
  assumes the core presents one access per cycle with a one-cycle
  acc_req_i pulse; peripheral hardware answers io_rdata_i combinationally.
*/
// Contract
// (RULE_01) F80H..FFFH decodes as peripheral window
// (RULE_02) mem.bit reaches window if mbe0 or bank15
// (RULE_03) fixed-area bit mode always reaches window
// (RULE_04) pointer bit mode always reaches window
// (RULE_05) direct nibble reaches window if mbe0/bank15
// (RULE_06) indirect nibble needs mbe1 and bank15
// (RULE_07) direct byte needs even address, same qualification
// (RULE_08) indirect byte needs even low nibble, bank15
// (RULE_09) four banks of eight nibbles at 00H..1FH
// (RULE_10) pairs at base offsets 0,2,4,6
// (RULE_11) active bank is enable AND select
// (RULE_12) alternate pairs use bank bit0 inverted
// (RULE_13) only read readable, write writable locations
// (RULE_14) only permitted widths and partial bits
// (RULE_15) unqualified upper accesses go to data memory
`timescale 1ns/1ps
module gprm_map
  import gprm_pkg::*;
(
  input  wire logic        clk_i,        // core clock
  input  wire logic        rst_i,        // sync reset
  // wishbone slave
  input  wire logic        wb_cyc_i,     // cycle
  input  wire logic        wb_stb_i,     // strobe
  input  wire logic        wb_we_i,      // write enable
  input  wire logic [7:0]  wb_adr_i,     // byte address
  input  wire logic [3:0]  wb_sel_i,     // byte lanes
  input  wire logic [31:0] wb_dat_i,     // write data
  output logic      [31:0] wb_dat_o,     // read data
  output logic             wb_ack_o,     // acknowledge
  // core access port
  input  wire logic        acc_req_i,    // access request pulse
  input  wire logic        acc_we_i,     // write
  input  wire logic [2:0]  acc_mode_i,   // gprm_mode_e
  input  wire logic [1:0]  acc_width_i,  // gprm_width_e
  input  wire logic [11:0] acc_addr_i,   // nibble address
  input  wire logic [1:0]  acc_bit_i,    // bit index for 1-bit access
  input  wire logic        acc_alt_i,    // use alternate pair bank
  input  wire logic [1:0]  acc_pair_i,   // 0 acc,1 ptr,2 aux,3 cnt
  input  wire logic        acc_pair_en_i, // pair-relative register access
  input  wire logic [7:0]  acc_wdata_i,  // write data
  output logic      [7:0]  acc_rdata_o,  // read data (registered)
  output logic             acc_done_o,   // answer pulse
  output logic             acc_err_o,    // refused access pulse
  // peripheral side
  output logic             io_sel_o,     // peripheral access strobe
  output logic             io_we_o,      // peripheral write
  output logic      [6:0]  io_ofs_o,     // window offset
  output logic      [7:0]  io_wdata_o,   // write data
  output logic      [1:0]  io_width_o,   // access width
  input  wire logic [7:0]  io_rdata_i,   // peripheral read data
  // ordinary data memory side
  output logic             mem_sel_o,    // data memory strobe
  output logic             mem_we_o,     // data memory write
  output logic      [11:0] mem_addr_o,   // data memory address
  output logic      [7:0]  mem_wdata_o,  // write data
  output logic      [1:0]  mem_width_o,  // access width
  input  wire logic [7:0]  mem_rdata_i,  // data memory read data
  output logic      [1:0]  act_bank_o    // active register bank
);
  typedef struct packed {
    logic        memory_bank_enable;
    logic [3:0]  memory_bank_select;
    logic        register_bank_enable;
    logic [1:0]  register_bank_select;
    logic [7:0]  viol_cnt;
    logic        ack;
    logic [31:0] wdat;
    logic [7:0]  rdata;
    logic        done;
    logic        err;
    logic        io_sel;
    logic        io_we;
    logic [6:0]  io_ofs;
    logic [7:0]  io_wdata;
    logic [1:0]  io_width;
    logic        mem_sel;
    logic        mem_we;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [1:0]  mem_width;
    logic [1:0]  bank;
    logic [2:0]  last_tgt;
  } gprm_st_s;

  gprm_st_s st_r;
  gprm_st_s st_nxt;

  function automatic logic bank15_ok(input logic memory_bank_enable, input logic [3:0] memory_bank_select);
    return memory_bank_enable && (memory_bank_select == IO_BANK);
  endfunction

  function automatic logic [1:0] act_bank(input logic register_bank_enable, input logic [1:0] register_bank_select);
    return {register_bank_enable & register_bank_select[1], register_bank_enable & register_bank_select[0]}; // RULE_11
  endfunction

  logic [1:0]        bank_w;
  logic [1:0]        pbank_w;
  logic [11:0]       ea_w;
  logic              in_win;
  logic              qual;
  logic              is_greg;
  logic [ATTR_W-1:0] attr_w;
  logic              attr_ok;
  logic              wb_hit;
  logic [4:0]        rb_addr;
  logic              rb_we;
  logic [7:0]        rb_rdata;
  logic [2:0]        tgt;

  assign bank_w  = act_bank(st_r.register_bank_enable, st_r.register_bank_select);
  assign pbank_w = acc_alt_i ? {bank_w[1], ~bank_w[0]} : bank_w; // RULE_12
  // pair access resolves to bank base plus pair offset
  assign ea_w = acc_pair_en_i
              ? {7'h00, pbank_w, acc_pair_i, 1'b0} // RULE_10
              : acc_addr_i;
  assign in_win = (ea_w >= IO_BASE) && (ea_w <= IO_LAST); // RULE_01

  always_comb begin
    case (gprm_mode_e'(acc_mode_i))
      GPRM_M_BIT_MEM: qual = !st_r.memory_bank_enable || bank15_ok(st_r.memory_bank_enable, st_r.memory_bank_select); // RULE_02
      GPRM_M_BIT_FIX: qual = 1'b1; // RULE_03
      GPRM_M_BIT_PTR: qual = 1'b1; // RULE_04
      GPRM_M_DIR:     qual = !st_r.memory_bank_enable || bank15_ok(st_r.memory_bank_enable, st_r.memory_bank_select); // RULE_05 RULE_07
      GPRM_M_IND:     qual = bank15_ok(st_r.memory_bank_enable, st_r.memory_bank_select); // RULE_06 RULE_08
      default:        qual = 1'b0;
    endcase
  end

  gprm_attr u_attr (
    .ofs_i  (ea_w[6:0]),
    .attr_o (attr_w)
  );

  always_comb begin
    attr_ok = (acc_we_i ? attr_w[A_WR] : attr_w[A_RD]); // RULE_13
    case (gprm_width_e'(acc_width_i))
      GPRM_W_1: attr_ok = attr_ok && (attr_w[A_B1] ||
                          (attr_w[A_PRT] && acc_bit_i == 2'h3)); // RULE_14
      GPRM_W_4: attr_ok = attr_ok && attr_w[A_B4]; // RULE_14
      GPRM_W_8: attr_ok = attr_ok && attr_w[A_B8] && !ea_w[0]; // RULE_07 RULE_08
      default:  attr_ok = 1'b0;
    endcase
  end

  // general registers live in bank 0; plain addresses reach them only when bank settings point there, pair accesses always
  assign is_greg = (ea_w <= GREG_LAST) &&
                   (acc_pair_en_i || !st_r.memory_bank_enable || st_r.memory_bank_select == 4'h0); // RULE_09
  assign rb_addr = ea_w[4:0];
  assign rb_we   = acc_req_i && acc_we_i && is_greg && !(acc_width_i == GPRM_W_8 && ea_w[0]);

  gprm_regbank u_regs (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .addr_i  (rb_addr),
    .we_i    (rb_we),
    .wide_i  (acc_width_i == GPRM_W_8),
    .wdata_i (acc_wdata_i),
    .rdata_o (rb_rdata)
  );

  always_comb begin
    if (is_greg) begin
      tgt = GPRM_T_GREG;
    end else if (in_win && qual) begin
      tgt = GPRM_T_IO;
    end else begin
      tgt = GPRM_T_NONE; // RULE_15
    end
  end

  assign wb_hit = wb_cyc_i && wb_stb_i && !st_r.ack;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = wb_hit;
    st_nxt.done     = 1'b0;
    st_nxt.err      = 1'b0;
    st_nxt.io_sel   = 1'b0;
    st_nxt.mem_sel  = 1'b0;
    st_nxt.bank     = bank_w;
    if (wb_hit) begin
      case (wb_adr_i)
        REG_CTRL: st_nxt.wdat = {20'h0, st_r.memory_bank_select, 2'h0, st_r.register_bank_select, 2'h0,
                                 st_r.register_bank_enable, st_r.memory_bank_enable};
        REG_STAT: st_nxt.wdat = {27'h0, st_r.last_tgt, bank_w};
        REG_VIOL: st_nxt.wdat = {24'h0, st_r.viol_cnt};
        default:  st_nxt.wdat = 32'h0;
      endcase
      if (wb_we_i && wb_adr_i == REG_CTRL) begin
        if (wb_sel_i[0]) begin
          st_nxt.memory_bank_enable = wb_dat_i[CTRL_MBE_POS];
          st_nxt.register_bank_enable = wb_dat_i[CTRL_RBE_POS];
          st_nxt.register_bank_select = wb_dat_i[CTRL_RBS_POS +: 2];
        end
        if (wb_sel_i[1]) begin
          st_nxt.memory_bank_select = wb_dat_i[CTRL_MBS_POS +: 4];
        end
      end
      if (wb_we_i && wb_adr_i == REG_VIOL && wb_sel_i[0]) begin
        st_nxt.viol_cnt = 8'h00;
      end
    end
    if (acc_req_i) begin
      st_nxt.done     = 1'b1;
      st_nxt.last_tgt = tgt;
      case (gprm_tgt_e'(tgt))
        GPRM_T_GREG: st_nxt.rdata = rb_rdata;
        GPRM_T_IO: begin
          if (attr_ok) begin
            st_nxt.io_sel   = 1'b1;
            st_nxt.io_we    = acc_we_i;
            st_nxt.io_ofs   = ea_w[6:0];
            st_nxt.io_wdata = acc_wdata_i;
            st_nxt.io_width = acc_width_i;
            st_nxt.rdata    = acc_we_i ? 8'h00 : io_rdata_i;
          end else begin
            st_nxt.err      = 1'b1; // RULE_13 RULE_14
            st_nxt.rdata    = 8'h00;
            st_nxt.viol_cnt = st_r.viol_cnt + 8'h01; // counter saturation skipped
          end
        end
        default: begin
          st_nxt.mem_sel   = 1'b1; // RULE_15
          st_nxt.mem_we    = acc_we_i;
          st_nxt.mem_addr  = ea_w;
          st_nxt.mem_wdata = acc_wdata_i;
          st_nxt.mem_width = acc_width_i;
          st_nxt.rdata     = mem_rdata_i;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r          <= '0;
      st_r.last_tgt <= GPRM_T_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o    = st_r.wdat;
  assign wb_ack_o    = st_r.ack;
  assign acc_rdata_o = st_r.rdata;
  assign acc_done_o  = st_r.done;
  assign acc_err_o   = st_r.err;
  assign io_sel_o    = st_r.io_sel;
  assign io_we_o     = st_r.io_we;
  assign io_ofs_o    = st_r.io_ofs;
  assign io_wdata_o  = st_r.io_wdata;
  assign io_width_o  = st_r.io_width;
  assign mem_sel_o   = st_r.mem_sel;
  assign mem_we_o    = st_r.mem_we;
  assign mem_addr_o  = st_r.mem_addr;
  assign mem_wdata_o = st_r.mem_wdata;
  assign mem_width_o = st_r.mem_width;
  assign act_bank_o  = st_r.bank;

  a_ind_needs_bank15: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    acc_req_i && acc_mode_i == GPRM_M_IND && !(st_r.memory_bank_enable && st_r.memory_bank_select == IO_BANK)
    |=> !io_sel_o) else $error("indirect reached window without bank 15");
  a_fix_bit_io: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    acc_req_i && acc_mode_i == GPRM_M_BIT_FIX && in_win && attr_ok && !is_greg
    |=> io_sel_o) else $error("fixed bit access missed window");
  a_odd_byte_err: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    acc_req_i && tgt == GPRM_T_IO && acc_width_i == GPRM_W_8 && ea_w[0]
    |=> acc_err_o && !io_sel_o) else $error("odd byte accepted");
  a_bank_and: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    !st_r.register_bank_enable |=> act_bank_o == 2'h0) else $error("bank nonzero with enable clear");
  a_unqual_mem: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
    acc_req_i && !is_greg && !(in_win && qual) |=> mem_sel_o && !io_sel_o)
    else $error("unqualified access not sent to memory");
  a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  c_io_write: cover property (@(posedge clk_i) io_sel_o && io_we_o);
  c_refused: cover property (@(posedge clk_i) acc_err_o);
  c_mem_path: cover property (@(posedge clk_i) mem_sel_o);
  a_below_window: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    acc_req_i && ea_w < IO_BASE |=> !io_sel_o)
    else $error("access below window reached it");
  a_bit_mem_bank: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    acc_req_i && acc_mode_i == GPRM_M_BIT_MEM && st_r.memory_bank_enable && st_r.memory_bank_select != IO_BANK
    |=> !io_sel_o) else $error("bank bit access reached window outside bank 15");
  a_partial_bit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
    acc_req_i && tgt == GPRM_T_IO && acc_width_i == GPRM_W_1 && !attr_w[A_B1]
    && acc_bit_i != 2'h3 |=> !io_sel_o) else $error("bit outside partial set accepted");
  c_greg_bank: cover property (@(posedge clk_i) acc_done_o && act_bank_o != 2'h0);
  c_ind_io: cover property (@(posedge clk_i)
    acc_req_i && acc_mode_i == GPRM_M_IND && tgt == GPRM_T_IO);
endmodule

// File: gprm_pkg.sv
/*
  gprm_pkg: constants and types shared by the data-memory mapping block.
  assumes a 12-bit nibble data address space with 4-bit data words.
*/
package gprm_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] IO_BASE       = 12'hF80;
  localparam logic [11:0] IO_LAST       = 12'hFFF;
  localparam logic [11:0] GREG_LAST     = 12'h01F;
  localparam logic [3:0]  IO_BANK       = 4'hF;
  localparam logic [2:0]  OFS_ACC       = 3'h0;
  localparam logic [2:0]  OFS_PTR       = 3'h2;
  localparam logic [2:0]  OFS_AUX       = 3'h4;
  localparam logic [2:0]  OFS_CNT       = 3'h6;
  localparam logic [3:0]  NIB_RST       = 4'h0;

  // wishbone register offsets (byte addresses on a 32-bit bus)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STAT      = 8'h04;
  localparam logic [7:0]  REG_VIOL      = 8'h08;
  // ctrl field positions
  localparam int unsigned CTRL_MBE_POS  = 0;
  localparam int unsigned CTRL_RBE_POS  = 1;
  localparam int unsigned CTRL_RBS_POS  = 4;
  localparam int unsigned CTRL_MBS_POS  = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // access mode encoding from the core
  typedef enum logic [2:0] {
    GPRM_M_BIT_MEM  = 3'h0,  // bank-relative direct bit
    GPRM_M_BIT_FIX  = 3'h1,  // fixed-area direct bit
    GPRM_M_BIT_PTR  = 3'h2,  // pointer low nibble bit
    GPRM_M_DIR      = 3'h3,  // direct nibble / byte
    GPRM_M_IND      = 3'h4   // pointer_indirect_mode through data pointer pair
  } gprm_mode_e;

  typedef enum logic [1:0] {
    GPRM_W_1 = 2'h0,
    GPRM_W_4 = 2'h1,
    GPRM_W_8 = 2'h2
  } gprm_width_e;

  // attribute bits per peripheral nibble: rd, wr, 1-bit, 4-bit, 8-bit, partial
  localparam int unsigned ATTR_W = 6;
  localparam int unsigned A_RD  = 0;
  localparam int unsigned A_WR  = 1;
  localparam int unsigned A_B1  = 2;
  localparam int unsigned A_B4  = 3;
  localparam int unsigned A_B8  = 4;
  localparam int unsigned A_PRT = 5;

  typedef enum logic [2:0] {
    GPRM_T_NONE = 3'b001,
    GPRM_T_GREG = 3'b010,
    GPRM_T_IO   = 3'b100
  } gprm_tgt_e;
endpackage

// File: gprm_regbank.sv
/*
  gprm_regbank: four banks of eight nibble general registers at 00H..1FH.
  assumes one nibble write or one byte write per cycle from the decoder.
*/
`timescale 1ns/1ps
module gprm_regbank
  import gprm_pkg::*;
(
  input  wire logic       clk_i,     // core clock
  input  wire logic       rst_i,     // sync reset
  input  wire logic [4:0] addr_i,    // nibble address within area
  input  wire logic       we_i,      // write strobe
  input  wire logic       wide_i,    // byte write (addr bit0 ignored)
  input  wire logic [7:0] wdata_i,   // write data
  output logic      [7:0] rdata_o    // byte at even address at or below addr; zero-extended nibble if not wide
);
  typedef struct packed {
    logic [31:0][3:0] nib;
  } gprm_rb_s;

  gprm_rb_s st_r;
  gprm_rb_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (we_i) begin
      if (wide_i) begin
        st_nxt.nib[{addr_i[4:1], 1'b0}] = wdata_i[3:0];
        st_nxt.nib[{addr_i[4:1], 1'b1}] = wdata_i[7:4];
      end else begin
        st_nxt.nib[addr_i] = wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = wide_i ? {st_r.nib[{addr_i[4:1], 1'b1}], st_r.nib[{addr_i[4:1], 1'b0}]}
                          : {4'h0, st_r.nib[addr_i]};
endmodule
